// [inc/vts_pkg.sv]
// constants, types and helpers shared by the vid target sequencer
package vts_pkg;

   // ===================================================================
   // widths
   // ===================================================================
   localparam int LEVEL_W = 8;
   localparam int CODE_W  = 7;
   localparam int ADDR_W  = 8;
   localparam int SYNC_W  = 12;

   // ===================================================================
   // target levels, one step is 12.5 mV
   // ===================================================================
   localparam logic [7:0] VID_TOP_LEVEL = 8'h7c;
   localparam logic [7:0] OFFSET_LEVEL  = 8'h01;
   localparam logic [7:0] BOOT_LVL_00   = 8'h58;
   localparam logic [7:0] BOOT_LVL_01   = 8'h50;
   localparam logic [7:0] BOOT_LVL_10   = 8'h48;
   localparam logic [7:0] BOOT_LVL_11   = 8'h40;

   // ===================================================================
   // serial frame layout
   // ===================================================================
   localparam logic [3:0] ADDR_PREFIX = 4'hc;
   localparam int         SEL_CORE_A  = 0;
   localparam int         SEL_CORE_B  = 1;
   localparam int         SEL_NB      = 2;
   localparam int         DATA_PSI    = 7;

   // ===================================================================
   // register map
   // ===================================================================
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CTRL   = 8'h04;
   localparam logic [7:0] REG_TGT_A  = 8'h08;
   localparam logic [7:0] REG_TGT_B  = 8'h0c;
   localparam logic [7:0] REG_TGT_NB = 8'h10;
   localparam logic [7:0] SLEW_RST   = 8'h04;
   localparam int ST_F_STATE = 0;
   localparam int ST_F_COMB  = 2;
   localparam int ST_F_GSB   = 3;
   localparam int ST_F_BOOT  = 4;
   localparam int ST_F_PWM   = 6;
   localparam int ST_F_INTEG = 9;
   localparam int ST_F_PSI   = 12;
   localparam int TG_F_CODE  = 8;

   typedef enum logic [1:0]
   {
      VTS_OFF    = 2'b00,
      VTS_BOOT   = 2'b01,
      VTS_HELD   = 2'b10,
      VTS_SERIAL = 2'b11
   } vts_state_t;

   typedef enum logic [1:0]
   {
      VTS_RX_IDLE = 2'b00,
      VTS_RX_BITS = 2'b01,
      VTS_RX_ACK  = 2'b10,
      VTS_RX_SKIP = 2'b11
   } vts_rx_state_t;

   // table code to target level
   function automatic logic [7:0] vts_vid_level(input logic [6:0] code);
      vts_vid_level = ({1'b0, code} > VID_TOP_LEVEL) ? 8'h00
                      : VID_TOP_LEVEL - {1'b0, code};
   endfunction

   // boot pins (clock, data) to table code
   function automatic logic [6:0] vts_boot_code(input logic [1:0] pins);
      logic [7:0] lvl;
      case (pins)
         2'b00:   lvl = BOOT_LVL_00;
         2'b01:   lvl = BOOT_LVL_01;
         2'b10:   lvl = BOOT_LVL_10;
         default: lvl = BOOT_LVL_11;
      endcase
      vts_boot_code = 7'(VID_TOP_LEVEL - lvl);
   endfunction

endpackage

// [inc/vts_frame_if.sv]
// received serial write frame passed from receiver to core
`timescale 1ns/1ns
interface vts_frame_if;
   logic       valid;
   logic [6:0] addr;
   logic [7:0] data;
   modport rx   (output valid, output addr, output data);
   modport core (input valid, input addr, input data);
endinterface

// [core/vts_ramp.sv]
// one slewed target level moving a step at a time toward its goal
`timescale 1ns/1ns
module vts_ramp
#(
   parameter int LEVEL_W = 8
)
(
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               hold_zero,
   input  wire logic [LEVEL_W-1:0] goal,
   input  wire logic [7:0]         step_period,
   output logic      [LEVEL_W-1:0] level,
   output logic                    settled,
   output logic                    falling
);
   logic [7:0] cnt_r;
   wire        step_due = (cnt_r >= step_period);

   assign settled = (level == goal);
   assign falling = (goal < level);

   always_ff @(posedge sys_clk)
   begin
      if (rst || hold_zero)
      begin
         level <= '0;
         cnt_r <= 8'h00;
      end
      else if (settled || step_due)
      begin
         cnt_r <= 8'h00;
         if (!settled)
            level <= falling ? level - 1'b1 : level + 1'b1;
      end
      else
         cnt_r <= cnt_r + 8'h01;
   end
endmodule

// [core/vts_ser_rx.sv]
// write-only two-wire serial slave, oversampled on the system clock
`timescale 1ns/1ns
module vts_ser_rx
(
   input  wire logic   sys_clk,
   input  wire logic   rst,
   input  wire logic   active,
   input  wire logic   scl,
   input  wire logic   sda,
   output logic        sda_oe_n,
   vts_frame_if.rx     frame
);
   vts_pkg::vts_rx_state_t state_r;
   logic       scl_prev_r;
   logic       sda_prev_r;
   logic [7:0] shift_r;
   logic [3:0] bit_cnt_r;
   logic       data_byte_r;

   wire start  = scl && sda_prev_r && !sda;
   wire stop   = scl && !sda_prev_r && sda;
   wire rise   = scl && !scl_prev_r;
   wire fall   = !scl && scl_prev_r;
   wire addr_ok = (shift_r[7:4] == vts_pkg::ADDR_PREFIX) && !shift_r[0];

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_r     <= vts_pkg::VTS_RX_IDLE;
         scl_prev_r  <= 1'b1;
         sda_prev_r  <= 1'b1;
         shift_r     <= 8'h00;
         bit_cnt_r   <= 4'h0;
         data_byte_r <= 1'b0;
         sda_oe_n    <= 1'b1;
         frame.valid <= 1'b0;
         frame.addr  <= 7'h00;
         frame.data  <= 8'h00;
      end
      else
      begin
         scl_prev_r  <= scl;
         sda_prev_r  <= sda;
         frame.valid <= 1'b0;
         if (!active || stop)
         begin
            state_r  <= vts_pkg::VTS_RX_IDLE;
            sda_oe_n <= 1'b1;
         end
         else if (start)
         begin
            state_r     <= vts_pkg::VTS_RX_BITS;
            bit_cnt_r   <= 4'h0;
            data_byte_r <= 1'b0;
            sda_oe_n    <= 1'b1;
         end
         else
         begin
            case (state_r)
               vts_pkg::VTS_RX_BITS:
               begin
                  if (rise)
                  begin
                     shift_r   <= {shift_r[6:0], sda};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
                  else if (fall && bit_cnt_r == 4'h8)
                  begin
                     if (data_byte_r)
                     begin
                        frame.data  <= shift_r;
                        frame.valid <= 1'b1;
                        sda_oe_n    <= 1'b0;
                        state_r     <= vts_pkg::VTS_RX_ACK;
                     end
                     else if (addr_ok)
                     begin
                        frame.addr <= shift_r[7:1];
                        sda_oe_n   <= 1'b0;
                        state_r    <= vts_pkg::VTS_RX_ACK;
                     end
                     else
                        state_r <= vts_pkg::VTS_RX_SKIP;
                  end
               end
               vts_pkg::VTS_RX_ACK:
               begin
                  if (fall)
                  begin
                     sda_oe_n    <= 1'b1;
                     bit_cnt_r   <= 4'h0;
                     data_byte_r <= 1'b1;
                     state_r     <= data_byte_r ? vts_pkg::VTS_RX_SKIP
                                                : vts_pkg::VTS_RX_BITS;
                  end
               end
               default:
                  sda_oe_n <= 1'b1;
            endcase
         end
      end
   end
endmodule

// [core/vts_top.sv]
// vid target sequencer: modes, boot voltage, serial targets, apb view
//
// Behaviour
// - both ground-sense straps low give separate mode, either high combined
// - combined mode senses ground on the strap not pulled high
// - straps sampled at reference-ready rise, held until shutdown cycles
// - integrator off in pulse-skip falls until settled and comparator edge
// - write-only serial slave, clock rates 100 kHz to 3.4 MHz
// - serial traffic ignored until system power ok has gone high
// - serial writes set three dac codes and power-state bits, applied
// - while output power good low, serial pins read as boot code
// - core target is dac level plus optional 12.5 mV offset
// - northbridge target is dac level plus fixed 12.5 mV offset
// - three independent 7-bit dacs, two core and one northbridge
// - targets ramp from ground to boot level, following boot pin changes
// - boot code latched at power good, later pin changes ignored
// - system power ok rise ends boot mode, serial sets any code
// - system power ok fall after latch returns all dacs to boot
// - boot code 00,01,10,11 gives 1.1,1.0,0.9,0.8 volts
// - core offset only in serial mode and when option strap enables
// - core offset removed while power-state bit selects light load
// - after boot, power-state bit 0 pulse-skip, 1 forced fixed frequency
// - pulse-skip on every output throughout startup
`timescale 1ns/1ns
module vts_top
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_vid_clock,
   input  wire logic        serial_vid_data_in,
   output logic             serial_vid_data_out,
   output logic             serial_vid_data_oe_n,
   input  wire logic        ground_sense_strap_a,
   input  wire logic        ground_sense_strap_b,
   input  wire logic        reference_ready,
   input  wire logic        shutdown_n_pin,
   input  wire logic        system_power_ok_in,
   input  wire logic        output_power_good,
   input  wire logic        option_strap_high,
   input  wire logic [2:0]  error_comparator,
   output logic             combined_mode,
   output logic             ground_sense_use_b,
   output logic      [7:0]  core_a_target,
   output logic      [7:0]  core_b_target,
   output logic      [7:0]  nb_target,
   output logic      [2:0]  forced_pwm,
   output logic      [2:0]  integrator_en,
   output logic             serial_active
);
   localparam int LW = vts_pkg::LEVEL_W;
   localparam int SW = vts_pkg::SYNC_W;

   // ===================================================================
   // pin synchronisers
   // ===================================================================
   logic [SW-1:0] pin_meta_r;
   logic [SW-1:0] pin_sync_r;
   logic [SW-1:0] pin_prev_r;
   wire  [SW-1:0] pin_raw = {error_comparator, option_strap_high,
                             shutdown_n_pin, output_power_good,
                             system_power_ok_in, reference_ready,
                             ground_sense_strap_b, ground_sense_strap_a,
                             serial_vid_data_in, serial_vid_clock};

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
         pin_prev_r <= '0;
      end
      else
      begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   wire       scl_s     = pin_sync_r[0];
   wire       sda_s     = pin_sync_r[1];
   wire       strap_a_s = pin_sync_r[2];
   wire       strap_b_s = pin_sync_r[3];
   wire       ref_rise  = pin_sync_r[4] && !pin_prev_r[4];
   wire       pok_s     = pin_sync_r[5];
   wire       pg_s      = pin_sync_r[6];
   wire       shutdown_n_pin_n_s  = pin_sync_r[7];
   wire       opt_hi_s  = pin_sync_r[8];
   wire [2:0] err_edge  = pin_sync_r[11:9] ^ pin_prev_r[11:9];

   // ===================================================================
   // sequencing state
   // ===================================================================
   vts_pkg::vts_state_t state_r;
   logic       combined_r;
   logic       gsense_b_r;
   logic [1:0] boot_pins_r;
   logic [6:0] dac_code_r [3];
   logic [2:0] psi_r;
   logic [7:0] slew_period_r;

   wire [1:0] boot_live  = {scl_s, sda_s};
   wire       in_serial  = (state_r == vts_pkg::VTS_SERIAL);
   wire       in_off     = (state_r == vts_pkg::VTS_OFF);
   wire [6:0] boot_code  = vts_pkg::vts_boot_code(boot_pins_r);
   wire [6:0] live_code  = vts_pkg::vts_boot_code(boot_live);
   wire [2:0] settled;
   wire [2:0] falling;
   wire       boot_done  = pg_s && (&settled);

   // ===================================================================
   // received frames
   // ===================================================================
   vts_frame_if frame_bus ();

   vts_ser_rx u_rx
   (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .active   (in_serial),
      .scl      (scl_s),
      .sda      (sda_s),
      .sda_oe_n (serial_vid_data_oe_n),
      .frame    (frame_bus.rx)
   );

   wire       frame_take = frame_bus.valid && in_serial;
   wire [2:0] frame_sel  = frame_bus.addr[2:0];
   wire       frame_psi  = frame_bus.data[vts_pkg::DATA_PSI];
   wire [6:0] frame_code = frame_bus.data[6:0];

   assign serial_vid_data_out = 1'b0;
   assign serial_active       = in_serial;

   always_ff @(posedge sys_clk)
   begin
      if (rst || !shutdown_n_pin_n_s)
      begin
         state_r     <= vts_pkg::VTS_OFF;
         combined_r  <= 1'b0;
         gsense_b_r  <= 1'b0;
         boot_pins_r <= 2'b00;
         psi_r       <= 3'b000;
      end
      else
      begin
         case (state_r)
            vts_pkg::VTS_OFF:
            begin
               if (ref_rise)
               begin
                  combined_r  <= strap_a_s || strap_b_s;
                  gsense_b_r  <= strap_a_s;
                  boot_pins_r <= boot_live;
                  state_r     <= vts_pkg::VTS_BOOT;
               end
            end
            vts_pkg::VTS_BOOT:
            begin
               if (!pg_s)
                  boot_pins_r <= boot_live;
               else if (boot_done)
                  state_r <= vts_pkg::VTS_HELD;
            end
            vts_pkg::VTS_HELD:
            begin
               if (pok_s)
                  state_r <= vts_pkg::VTS_SERIAL;
            end
            default:
            begin
               if (!pok_s)
                  state_r <= vts_pkg::VTS_HELD;
               else if (frame_take)
               begin
                  for (int i = 0; i < 3; i++)
                  begin
                     if (frame_sel[i])
                        psi_r[i] <= frame_psi;
                  end
               end
            end
         endcase
      end
   end

   // ===================================================================
   // dac codes
   // ===================================================================
   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (rst || in_off)
            dac_code_r[i] <= vts_pkg::VID_TOP_LEVEL[6:0];
         else if (state_r == vts_pkg::VTS_BOOT && !pg_s)
            dac_code_r[i] <= live_code;
         else if (in_serial && !pok_s)
            dac_code_r[i] <= boot_code;
         else if (frame_take && frame_sel[i])
            dac_code_r[i] <= frame_code;
      end
   end

   // ===================================================================
   // slewed targets and loop controls
   // ===================================================================
   logic [LW-1:0] level      [3];
   logic [LW-1:0] target_r   [3];
   logic [2:0]    integ_en_r;
   wire           offset_ok  = in_serial && !opt_hi_s;
   wire  [2:0]    pwm_mode   = in_serial ? psi_r : 3'b000;
   wire  [2:0]    add_offset = {1'b1, {2{offset_ok}} & psi_r[1:0]};

   for (genvar g = 0; g < 3; g++)
   begin : g_out
      vts_ramp #(.LEVEL_W(LW)) u_ramp
      (
         .sys_clk     (sys_clk),
         .rst         (rst),
         .hold_zero   (in_off),
         .goal        (vts_pkg::vts_vid_level(dac_code_r[g])),
         .step_period (slew_period_r),
         .level       (level[g]),
         .settled     (settled[g]),
         .falling     (falling[g])
      );

      always_ff @(posedge sys_clk)
      begin
         if (rst || in_off)
            target_r[g] <= '0;
         else if (add_offset[g])
            target_r[g] <= level[g] + vts_pkg::OFFSET_LEVEL;
         else
            target_r[g] <= level[g];
      end

      always_ff @(posedge sys_clk)
      begin
         if (rst || in_off)
            integ_en_r[g] <= 1'b1;
         else if (falling[g] && !pwm_mode[g])
            integ_en_r[g] <= 1'b0;
         else if (settled[g] && err_edge[g])
            integ_en_r[g] <= 1'b1;
      end
   end

   assign core_a_target      = target_r[0];
   assign core_b_target      = target_r[1];
   assign nb_target          = target_r[2];
   assign forced_pwm         = pwm_mode;
   assign integrator_en      = integ_en_r;
   assign combined_mode      = combined_r;
   assign ground_sense_use_b = gsense_b_r;

   // ===================================================================
   // apb slave
   // ===================================================================
   wire sel_status = (paddr == vts_pkg::REG_STATUS);
   wire sel_ctrl   = (paddr == vts_pkg::REG_CTRL);
   wire sel_tgt_a  = (paddr == vts_pkg::REG_TGT_A);
   wire sel_tgt_b  = (paddr == vts_pkg::REG_TGT_B);
   wire sel_tgt_nb = (paddr == vts_pkg::REG_TGT_NB);
   wire addr_hit   = sel_status || sel_ctrl || sel_tgt_a || sel_tgt_b
                     || sel_tgt_nb;
   wire apb_setup  = psel && !penable;
   wire apb_write  = psel && penable && pwrite && sel_ctrl && pstrb[0];

   logic [31:0] status_w;
   logic [31:0] tgt_w [3];
   logic [31:0] rd_mux;

   always_comb
   begin
      status_w = 32'h0000_0000;
      status_w[vts_pkg::ST_F_STATE +: 2] = state_r;
      status_w[vts_pkg::ST_F_COMB]       = combined_r;
      status_w[vts_pkg::ST_F_GSB]        = gsense_b_r;
      status_w[vts_pkg::ST_F_BOOT +: 2]  = boot_pins_r;
      status_w[vts_pkg::ST_F_PWM +: 3]   = pwm_mode;
      status_w[vts_pkg::ST_F_INTEG +: 3] = integ_en_r;
      status_w[vts_pkg::ST_F_PSI +: 3]   = psi_r;
      for (int i = 0; i < 3; i++)
      begin
         tgt_w[i] = 32'h0000_0000;
         tgt_w[i][LW-1:0] = target_r[i];
         tgt_w[i][vts_pkg::TG_F_CODE +: 7] = dac_code_r[i];
      end
   end

   assign rd_mux = sel_status ? status_w
                 : sel_ctrl   ? {24'h00_0000, slew_period_r}
                 : sel_tgt_a  ? tgt_w[0]
                 : sel_tgt_b  ? tgt_w[1]
                 : sel_tgt_nb ? tgt_w[2]
                 : 32'h0000_0000;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (apb_setup)
         prdata <= rd_mux;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         slew_period_r <= vts_pkg::SLEW_RST;
      else if (apb_write)
         slew_period_r <= pwdata[7:0];
   end
endmodule

// [verification/vts_props.sv]
// port-level assertions for the vid target sequencer
`timescale 1ns/1ns
module vts_props
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       shutdown_n_pin,
   input wire logic       system_power_ok_in,
   input wire logic       serial_vid_data_out,
   input wire logic       serial_vid_data_oe_n,
   input wire logic       combined_mode,
   input wire logic       ground_sense_use_b,
   input wire logic [7:0] core_a_target,
   input wire logic [7:0] nb_target,
   input wire logic [2:0] forced_pwm,
   input wire logic [2:0] integrator_en,
   input wire logic       serial_active
);
   // ==================================================================
   // sequences
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence sd_held;
      !shutdown_n_pin [*8];
   endsequence
   sequence pok_low;
      !system_power_ok_in [*8];
   endsequence
   sequence idle_8;
      !serial_active [*8];
   endsequence
   // ==================================================================
   // checks
   route_mode_a: assert property (ground_sense_use_b |-> combined_mode)
      else $error("ground route set outside combined mode");
   mode_hold_a: assert property (serial_active |-> $stable(combined_mode))
      else $error("mode latch moved in serial mode");
   sd_clear_a: assert property (sd_held |-> !combined_mode &&
      core_a_target == 8'h00 && nb_target == 8'h00)
      else $error("shutdown did not clear mode and targets");
   serial_gate_a: assert property (pok_low |-> !serial_active)
      else $error("serial mode without system power ok");
   boot_skip_a: assert property (!serial_active |-> forced_pwm == 3'b000)
      else $error("forced pwm outside serial mode");
   nb_offset_a: assert property (serial_active |-> nb_target != 8'h00)
      else $error("northbridge target lacks offset");
   open_drain_a: assert property (serial_vid_data_out == 1'b0)
      else $error("data line driven high");
   quiet_ack_a: assert property (idle_8 |-> serial_vid_data_oe_n)
      else $error("ack outside serial mode");
   integ_gate_a: assert property ($fell(integrator_en[0]) |->
      !$past(forced_pwm[0]))
      else $error("integrator off while in forced pwm");
endmodule

bind vts_top vts_props i_vts_props
(
   .sys_clk, .rst, .shutdown_n_pin, .system_power_ok_in,
   .serial_vid_data_out, .serial_vid_data_oe_n, .combined_mode,
   .ground_sense_use_b, .core_a_target, .nb_target, .forced_pwm,
   .integrator_en, .serial_active
);

// [verification/vts_ser_host.sv]
// serial bus master standing in for the host processor
`timescale 1ns/1ns
module vts_ser_host
(
   input  wire logic line,
   output logic      scl,
   output logic      sda
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // static levels read as boot code
   task pins(input logic c, input logic d);
      #1;
      scl = c;
      sda = d;
   endtask
   // one bit cell of half period h; s is the line mid high phase
   task put(input logic b, input int h, output logic s);
      scl = 1'b0;
      #(h / 4) sda = b;
      #(h - h / 4) scl = 1'b1;
      #(h / 2) s = line;
      #(h - h / 2);
   endtask
   // write-only frame, ack high when both bytes were answered
   task xfer(input logic [7:0] a, input logic [7:0] d, input int h,
             output logic ack);
      logic s;
      ack = 1'b1;
      #1 sda = 1'b0;
      #h;
      for (int k = 0; k < 2; k++)
      begin
         for (int i = 7; i >= 0; i--)
            put(k ? d[i] : a[i], h, s);
         put(1'b1, h, s);
         ack = ack & !s;
      end
      scl = 1'b0;
      #(h / 4) sda = 1'b0;
      #(h - h / 4) scl = 1'b1;
      #h sda = 1'b1;
      #h;
   endtask
endmodule

// [verification/test_vid_target_sequencer.sv]
// self-checking bench for the vid target sequencer
`timescale 1ns/1ns
module test_vid_target_sequencer;
   logic        sys_clk, rst, psel, penable, pwrite, scl, sda_m, sdn, rr;
   logic        gsa, gsb, pok, pg, opt, er, ack, comb, use_b, sact, oe_n;
   logic        dout, pready, pslverr;
   logic [2:0]  ec, fpwm, integ;
   logic [3:0]  pstrb;
   logic [7:0]  paddr, a, d, tga, tgb, tgn;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  bp;
   int          seed, failures, n_tests, lv[3], blv[4];
   bit          ps[3], ser;
   wire         line = sda_m & (oe_n | dout);

   vts_top i_vts_top
   (
      .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_vid_clock(scl), .serial_vid_data_in(line),
      .serial_vid_data_out(dout), .serial_vid_data_oe_n(oe_n),
      .ground_sense_strap_a(gsa), .ground_sense_strap_b(gsb),
      .reference_ready(rr), .shutdown_n_pin(sdn),
      .system_power_ok_in(pok), .output_power_good(pg),
      .option_strap_high(opt), .error_comparator(ec),
      .combined_mode(comb), .ground_sense_use_b(use_b),
      .core_a_target(tga), .core_b_target(tgb), .nb_target(tgn),
      .forced_pwm(fpwm), .integrator_en(integ), .serial_active(sact)
   );
   vts_ser_host i_vts_ser_host (.line(line), .scl(scl), .sda(sda_m));

   // ==================================================================
   // reference model and helpers
   function automatic logic [7:0] ex(input int i);
      ex = 8'(lv[i] + (i == 2 || (ser && !opt && ps[i])));
   endfunction
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", s, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task settle;
      int n;
      n = 0;
      while (n < 400 && (tga !== ex(0) || tgb !== ex(1) || tgn !== ex(2)
             || integ !== 3'b111 || sact !== ser))
      begin
         n++;
         @(negedge sys_clk);
      end
      chk("core_a", ex(0), tga);
      chk("core_b", ex(1), tgb);
      chk("nb", ex(2), tgn);
      chk("integ", 8'h07, 8'(integ));
      chk("serial", 8'(ser), {7'h0, sact});
      chk("pwm", 8'({ser & ps[2], ser & ps[1], ser & ps[0]}), 8'(fpwm));
      @(posedge sys_clk);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==================================================================
   // clock, watchdog, main sequence
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) ec <= ec + 3'h1;
   initial
   begin
      #300000;
      failures++;
      tally_and_finish;
   end
   initial
   begin
      seed = 29767;
      blv = '{8'h58, 8'h50, 8'h48, 8'h40};
      {psel, penable, pwrite, paddr, pwdata, ec} = '0;
      {gsa, gsb, rr, pok, pg, opt, ser} = '0;
      {rst, sdn, pstrb} = 6'h3f;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk("integ_rst", 8'h07, 8'(integ));
      apb(1'b0, 8'h04, 32'h0);
      chk("ctrl_rst", 8'h04, rd[7:0]);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk("ctrl", 8'h00, rd[7:0]);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 8'h01, {7'h0, er});
      for (int k = 0; k < 3; k++)
      begin
         sdn <= 1'b0;
         rr <= 1'b0;
         repeat (8) @(posedge sys_clk);
         gsa <= k == 1;
         gsb <= k == 2;
         sdn <= 1'b1;
         repeat (8) @(posedge sys_clk);
         rr <= 1'b1;
         repeat (8) @(posedge sys_clk);
         gsa <= k != 1;
         repeat (8) @(posedge sys_clk);
         chk("comb", 8'(k != 0), {7'h0, comb});
         chk("use_b", 8'(k == 1), {7'h0, use_b});
      end
      for (int p = 0; p < 5; p++)
      begin
         bp = (p < 4) ? 2'(p) : 2'($random(seed));
         i_vts_ser_host.pins(bp[1], bp[0]);
         lv = '{blv[bp], blv[bp], blv[bp]};
         settle;
      end
      pg <= 1'b1;
      settle;
      i_vts_ser_host.pins(!bp[1], !bp[0]);
      settle;
      i_vts_ser_host.pins(1'b1, 1'b1);
      i_vts_ser_host.xfer(8'hce, 8'h00, 16, ack);
      chk("ack_early", 8'h00, {7'h0, ack});
      settle;
      pok <= 1'b1;
      ser = 1'b1;
      settle;
      i_vts_ser_host.xfer(8'hcf, 8'h00, 16, ack);
      chk("ack_rw", 8'h00, {7'h0, ack});
      settle;
      for (int f = 0; f < 9; f++)
      begin
         a = 8'hc0 | (8'($random(seed)) & 8'h0e);
         a[1] = a[1] | (a[3:2] == 2'b00);
         d = 8'($random(seed));
         opt <= 1'($random(seed));
         i_vts_ser_host.xfer(a, d, f == 8 ? 5000 : 16, ack);
         chk("ack", 8'h01, {7'h0, ack});
         for (int i = 0; i < 3; i++)
            if (a[i + 1])
            begin
               lv[i] = d[6:0] > 7'h7c ? 0 : 8'h7c - d[6:0];
               ps[i] = d[7];
            end
         settle;
      end
      pok <= 1'b0;
      ser = 1'b0;
      lv = '{blv[bp], blv[bp], blv[bp]};
      settle;
      tally_and_finish;
   end
endmodule
